// >>> ptirq_defines.vh
// Register map, field positions and reset values of the pressure threshold interrupt block
`ifndef PTIRQ_DEFINES_VH
`define PTIRQ_DEFINES_VH
`define PTIRQ_ADDR_THS_LOW 8'h32
`define PTIRQ_ADDR_THS_HIGH 8'h33
`define PTIRQ_ADDR_CFG 8'h34
`define PTIRQ_ADDR_SRC 8'h35
`define PTIRQ_ADDR_ACK 8'h36
`define PTIRQ_THS_RESET 8'h00
`define PTIRQ_CFG_RESET 3'h0
`define PTIRQ_CFG_HIGH_EN 0
`define PTIRQ_CFG_LOW_EN 1
`define PTIRQ_CFG_LATCH 2
`define PTIRQ_SRC_HIGH 0
`define PTIRQ_SRC_LOW 1
`define PTIRQ_SRC_ACTIVE 2
`define PTIRQ_PAD_GND 3'h0
`define PTIRQ_PAD_HIGH 3'h1
`define PTIRQ_PAD_LOW 3'h2
`define PTIRQ_PAD_EITHER 3'h3
`define PTIRQ_PAD_DRDY 3'h4
`define PTIRQ_PAD_TRI 3'h7
`endif

// >>> ptirq_pad_route.v
// Routing of pressure events onto one interrupt pad by a three-bit code
`timescale 1ns/1ps
`default_nettype none
`include "ptirq_defines.vh"
module ptirq_pad_route (
	input wire [2:0] route_code,
	input wire high_event,
	input wire low_event,
	input wire data_ready,
	output reg pad_level,
	output reg pad_enable
);
	always @* begin
		pad_level = 1'b0;
		pad_enable = 1'b1;
		case (route_code)
			`PTIRQ_PAD_HIGH: pad_level = high_event;
			`PTIRQ_PAD_LOW: pad_level = low_event;
			`PTIRQ_PAD_EITHER: pad_level = high_event | low_event;
			`PTIRQ_PAD_DRDY: pad_level = data_ready;
			`PTIRQ_PAD_TRI: pad_enable = 1'b0;
			default: pad_level = 1'b0;
		endcase
	end
endmodule // ptirq_pad_route
`default_nettype wire

// >>> ptirq_core.v
// Threshold comparison, event source register and register access of the pressure interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ptirq_defines.vh"
// Notes on behaviour
// - Threshold is high byte then low byte
// - Threshold bytes reset to zero
// - High enable: delta above threshold requests
// - Low enable: delta below threshold requests
// - Latch bit holds flags until acknowledged
// - Latch and enables reset to zero
// - Active flag set when any event
// - Separate low and high event flags
// - Acknowledge read clears latched flags
// - Delta is reference minus measured pressure
// - Pads routed by three-bit code
module ptirq_core #(
	parameter REG_WIDTH = 8,
	parameter ADDR_WIDTH = 8
) (
	input wire clock,
	input wire nrst,
	input wire reg_write,
	input wire reg_read,
	input wire [ADDR_WIDTH-1:0] reg_addr,
	input wire [REG_WIDTH-1:0] reg_wdata,
	output reg [REG_WIDTH-1:0] reg_rdata,
	input wire sample_valid,
	input wire [2*REG_WIDTH-1:0] measured_pressure,
	input wire [2*REG_WIDTH-1:0] reference_pressure,
	input wire [2:0] first_pad_route,
	input wire [2:0] second_pad_route,
	output wire first_interrupt_pad,
	output wire first_interrupt_pad_oe,
	output wire second_interrupt_pad,
	output wire second_interrupt_pad_oe
);
	localparam PRESSURE_WIDTH = 2 * REG_WIDTH;

	reg [REG_WIDTH-1:0] threshold_low_byte;
	reg [REG_WIDTH-1:0] threshold_high_byte;
	reg high_event_enable;
	reg low_event_enable;
	reg latch_request_mode;
	reg high_event_flag;
	reg low_event_flag;
	reg data_ready;
	wire [PRESSURE_WIDTH-1:0] threshold;
	wire [PRESSURE_WIDTH-1:0] delta_pressure;
	wire high_hit;
	wire low_hit;
	wire ack_read;
	wire wr_threshold_low;
	wire wr_threshold_high;
	wire wr_config;
	wire interrupt_active_flag;
	wire [REG_WIDTH-1:0] config_view;
	wire [REG_WIDTH-1:0] source_view;
	wire [5:0] pad_routes;
	wire [1:0] pad_levels;
	wire [1:0] pad_enables;
	reg [REG_WIDTH-1:0] next_rdata;
	reg next_high;
	reg next_low;

	////////////////////////////////////////////////////////////////////////////
	// threshold assembly
	assign threshold = {threshold_high_byte, threshold_low_byte};
	assign delta_pressure = reference_pressure - measured_pressure;
	assign high_hit = high_event_enable && (delta_pressure > threshold);
	assign low_hit = low_event_enable && (delta_pressure < threshold);

	// Register access decode
	assign ack_read = reg_read && (reg_addr == `PTIRQ_ADDR_ACK);
	assign wr_threshold_low = reg_write && (reg_addr == `PTIRQ_ADDR_THS_LOW);
	assign wr_threshold_high = reg_write && (reg_addr == `PTIRQ_ADDR_THS_HIGH);
	assign wr_config = reg_write && (reg_addr == `PTIRQ_ADDR_CFG);

	assign interrupt_active_flag = high_event_flag | low_event_flag;

	assign config_view = {{(REG_WIDTH-3){1'h0}}, latch_request_mode, low_event_enable,
		high_event_enable};
	assign source_view = {{(REG_WIDTH-3){1'h0}}, interrupt_active_flag, low_event_flag,
		high_event_flag};

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	// threshold low byte reset
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			threshold_low_byte <= `PTIRQ_THS_RESET;
		end else if (wr_threshold_low) begin
			threshold_low_byte <= reg_wdata;
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			threshold_high_byte <= `PTIRQ_THS_RESET;
		end else if (wr_threshold_high) begin
			threshold_high_byte <= reg_wdata;
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			{latch_request_mode, low_event_enable, high_event_enable} <= `PTIRQ_CFG_RESET;
		end else if (wr_config) begin
			high_event_enable <= reg_wdata[`PTIRQ_CFG_HIGH_EN];
			low_event_enable <= reg_wdata[`PTIRQ_CFG_LOW_EN];
			latch_request_mode <= reg_wdata[`PTIRQ_CFG_LATCH];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event flags
	always @* begin
		next_high = high_event_flag;
		next_low = low_event_flag;
		if (!latch_request_mode) begin
			if (sample_valid) begin
				next_high = high_hit;
				next_low = low_hit;
			end
		end else begin
			if (ack_read) begin
				next_high = 1'b0;
				next_low = 1'b0;
			end
			// new sample sets, wins over clear
			if (sample_valid) begin
				next_high = next_high | high_hit;
				next_low = next_low | low_hit;
			end
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			high_event_flag <= 1'h0;
			low_event_flag <= 1'h0;
		end else begin
			high_event_flag <= next_high;
			low_event_flag <= next_low;
		end
	end

	// Data ready pulse, one cycle after each sample
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_ready <= 1'h0;
		end else begin
			data_ready <= sample_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, held until the next read
	always @* begin
		next_rdata = reg_rdata;
		if (reg_read) begin
			case (reg_addr)
				`PTIRQ_ADDR_THS_LOW: next_rdata = threshold_low_byte;
				`PTIRQ_ADDR_THS_HIGH: next_rdata = threshold_high_byte;
				`PTIRQ_ADDR_CFG: next_rdata = config_view;
				`PTIRQ_ADDR_SRC: next_rdata = source_view;
				default: next_rdata = {REG_WIDTH{1'h0}};
			endcase
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= {REG_WIDTH{1'h0}};
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad routing, one decoder per pad
	assign pad_routes = {second_pad_route, first_pad_route};
	assign first_interrupt_pad = pad_levels[0];
	assign first_interrupt_pad_oe = pad_enables[0];
	assign second_interrupt_pad = pad_levels[1];
	assign second_interrupt_pad_oe = pad_enables[1];

	genvar pad_index;
	generate
		for (pad_index = 0; pad_index < 2; pad_index = pad_index + 1) begin : g_pad
			ptirq_pad_route u_route (
				.route_code(pad_routes[3*pad_index +: 3]),
				.high_event(high_event_flag),
				.low_event(low_event_flag),
				.data_ready(data_ready),
				.pad_level(pad_levels[pad_index]),
				.pad_enable(pad_enables[pad_index])
			);
		end
	endgenerate

endmodule // ptirq_core
`default_nettype wire

// >>> ptirq_host.sv
// Host side register access model
`timescale 1ns/1ps
`default_nettype none
module ptirq_host (
	input wire logic clock,
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial begin
		{wr, rd, addr, wdata} = 18'h0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		{wr, rd, addr, wdata} = {w, !w, a, d};
		@(negedge clock);
		{wr, rd, addr, wdata} = {2'b00, ~a, ~d};
	endtask
endmodule // ptirq_host
`default_nettype wire

// >>> ptirq_core_asserts.sv
// Checker for the pressure interrupt core
`timescale 1ns/1ps
`default_nettype none
module ptirq_core_asserts (
	input wire logic clock,
	input wire logic nrst,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [2:0] first_pad_route,
	input wire logic [2:0] second_pad_route,
	input wire logic first_interrupt_pad,
	input wire logic first_interrupt_pad_oe,
	input wire logic second_interrupt_pad
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence src_rd; reg_read && reg_addr == 8'h35; endsequence
	sequence drdy_go; first_pad_route == 3'h4 && sample_valid ##1 !sample_valid; endsequence
	a_src_upper_zero: assert property (src_rd |=> reg_rdata[7:3] == 5'h00) else $error("src upper");
	a_active_is_or: assert property (src_rd |=> reg_rdata[2] == |reg_rdata[1:0]) else $error("active");
	a_ack_reads_zero: assert property (reg_read && reg_addr == 8'h36 |=> reg_rdata == 8'h00) else $error("ack");
	a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata hold");
	a_tri_only_111: assert property (first_interrupt_pad_oe == (first_pad_route != 3'h7)) else $error("oe");
	a_either_covers: assert property (first_pad_route == 3'h1 && second_pad_route == 3'h3 && first_interrupt_pad |-> second_interrupt_pad) else $error("either");
	a_drdy_pulse: assert property (drdy_go |-> first_interrupt_pad ##1 !first_interrupt_pad) else $error("drdy");
	a_reset_rdata: assert property ($rose(nrst) |-> reg_rdata == 8'h00) else $error("reset rdata");
endmodule // ptirq_core_asserts
bind ptirq_core ptirq_core_asserts chk_u (.clock(clock), .nrst(nrst), .reg_read(reg_read),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
	.first_pad_route(first_pad_route), .second_pad_route(second_pad_route),
	.first_interrupt_pad(first_interrupt_pad), .first_interrupt_pad_oe(first_interrupt_pad_oe),
	.second_interrupt_pad(second_interrupt_pad));
`default_nettype wire

// >>> tb_top.sv
// Testbench of the pressure interrupt core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0, nrst = 1'b0, sv = 1'b0, wr, rd;
	logic [7:0] addr, wdata, rdata;
	logic [15:0] meas = 16'h0000;
	logic [2:0] r1 = 3'h1, r2 = 3'h3, c, e;
	logic [15:0] t, m;
	logic p1, p1oe, p2, p2oe;
	logic [37:0] rows [0:6] = '{{3'h3, 16'h0100, 16'h0E00, 3'h5}, {3'h3, 16'h0100, 16'h0F80, 3'h6},
		{3'h3, 16'h0100, 16'h0F00, 3'h0}, {3'h1, 16'h0100, 16'h0F80, 3'h0},
		{3'h2, 16'h0100, 16'h0E00, 3'h0}, {3'h0, 16'h0100, 16'h0E00, 3'h0},
		{3'h3, 16'h8000, 16'h1001, 3'h5}};
	int errors = 0, checks_done = 0;
	initial forever #4 clock = ~clock;
	ptirq_host host_u (.clock(clock), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
	ptirq_core dut_u (.clock(clock), .nrst(nrst), .reg_write(wr), .reg_read(rd), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .sample_valid(sv), .measured_pressure(meas),
		.reference_pressure(16'h1000), .first_pad_route(r1), .second_pad_route(r2),
		.first_interrupt_pad(p1), .first_interrupt_pad_oe(p1oe), .second_interrupt_pad(p2),
		.second_interrupt_pad_oe(p2oe));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
		checks_done++;
		if (s !== x) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic smp(input logic [15:0] v);
		@(negedge clock);
		{sv, meas} = {1'b1, v};
		@(negedge clock);
		{sv, meas} = {1'b0, ~v};
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
		host_u.acc(1'b0, a, 8'hA5);
		chk("rdata", rdata, x);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(negedge clock);
		nrst = 1'b1;
		for (int a = 8'h32; a < 8'h35; a++) rd_chk(a[7:0], 8'h00);
		$display("reset test done");
		for (int i = 0; i < 7; i++) begin
			{c, t, m, e} = rows[i];
			host_u.acc(1'b1, 8'h32, t[7:0]);
			host_u.acc(1'b1, 8'h33, t[15:8]);
			host_u.acc(1'b1, 8'h34, {5'h00, c});
			smp(m);
			rd_chk(8'h35, {5'h00, e});
			chk("pads", {4'h0, p1oe, p1, p2oe, p2}, {4'h0, 1'h1, e[0], 1'h1, e[0] | e[1]});
		end
		rd_chk(8'h36, 8'h00);
		rd_chk(8'h35, 8'h05);
		$display("row test done");
		r1 = 3'h4;
		host_u.acc(1'b1, 8'h34, 8'h07);
		host_u.acc(1'b1, 8'h33, 8'h01);
		smp(16'h0E00);
		smp(16'h0F00);
		rd_chk(8'h35, 8'h05);
		host_u.acc(1'b1, 8'h35, 8'hFF);
		rd_chk(8'h35, 8'h05);
		rd_chk(8'h36, 8'h00);
		rd_chk(8'h35, 8'h00);
		rd_chk(8'h40, 8'h00);
		r1 = 3'h7;
		@(negedge clock);
		chk("pad oe", {7'h00, p1oe}, 8'h00);
		$display("latch test done");
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		rd_chk(8'h33, 8'h00);
		rd_chk(8'h34, 8'h00);
		$display("second reset test done");
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
